/* logic/adc_conversion_mode_control.sv */
// Behaviour
// - flag set on single or dma end
// - flag cleared when interrupt vector taken
// - dma bit arms memory capture mode for the next start
// - dma bit self-clears at capture end
// - address strobe stops until dma starts
// - continuous bit repeats conversions with settings
// - next conversion starts right after previous
// - single bit runs exactly one conversion
// - single bit self-clears when conversion ends
// - four-bit field selects channels zero-seven
// - non-dma conversions use selected channel field
// - dma mode takes channel from memory
// - register resets zero, bit addressable, d8
// - higher codes; temp sensor needs 1us
// - all-ones memory entry ends dma sequence
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_mode_control (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_val,
    input wire logic vector_ack,
    input wire logic trigger_in,
    input wire logic conv_done,
    input wire logic dma_entry_valid,
    input wire logic [3:0] dma_entry_chan,
    output logic [7:0] sfr_rdata,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic dma_fetch,
    output logic ale_enable,
    output logic conv_irq,
    output logic busy
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    adc_ctrl_pkg::seq_state_type state_q;
    adc_ctrl_pkg::seq_state_type state_d;
    logic dma_run_q;
    logic dma_run_d;
    logic [7:0] rdata_q;
    logic start_q;
    logic [3:0] chan_q;
    logic fetch_q;
    logic ale_q;
    logic busy_q;

    wire sfr_hit;
    wire bit_hit;
    wire [7:0] bit_mask;
    wire [7:0] touch;
    wire [7:0] sw_val;
    wire start_req;
    wire in_conv_done;
    wire stop_seen;
    wire single_end;
    wire dma_end;
    wire flag_set;
    wire enter_acq;
    wire acq_done;
    wire [3:0] sel_chan;
    wire sel_stop;
    wire sel_long;
    wire [adc_ctrl_pkg::ACQ_CNT_W-1:0] acq_len;

    assign sfr_hit = sfr_wr && (sfr_addr == adc_ctrl_pkg::CTRL_ADDR);
    assign bit_hit = bit_wr && (bit_addr[7:3] == adc_ctrl_pkg::CTRL_ADDR[7:3]);
    assign bit_mask = 8'h01 << bit_addr[2:0];
    assign touch = sfr_hit ? 8'hff : (bit_hit ? bit_mask : 8'h00);
    assign sw_val = sfr_hit ? sfr_wdata : (bit_val ? bit_mask : 8'h00);

    assign start_req = ctrl_q[adc_ctrl_pkg::SINGLE_CONVERSION_BIT_POS] || ctrl_q[adc_ctrl_pkg::CONTINUOUS_CONVERSION_BIT_POS]
        || trigger_in;
    assign in_conv_done = (state_q == adc_ctrl_pkg::ST_CONV) && conv_done;
    assign stop_seen = (state_q == adc_ctrl_pkg::ST_FETCH) && dma_entry_valid && sel_stop;
    // one conversion ends a single request
    assign single_end = in_conv_done && !dma_run_q;
    assign dma_end = stop_seen;
    assign flag_set = single_end || dma_end;

    assign enter_acq = (state_d == adc_ctrl_pkg::ST_ACQ) && (state_q != adc_ctrl_pkg::ST_ACQ);

    channel_select u_sel (
        .dma_mode(dma_run_q),
        .field_chan(ctrl_q[adc_ctrl_pkg::CHAN_MSB:0]),
        .mem_chan(dma_entry_chan),
        .chan(sel_chan),
        .is_stop(sel_stop),
        .long_acq(sel_long)
    );

    assign acq_len = sel_long ? adc_ctrl_pkg::ACQ_CNT_W'(adc_ctrl_pkg::TEMP_ACQ_CYC)
        : adc_ctrl_pkg::ACQ_CNT_W'(adc_ctrl_pkg::BASE_ACQ_CYC);

    acq_timer #(
        .CNT_W(adc_ctrl_pkg::ACQ_CNT_W)
    ) u_acq (
        .sys_clk(sys_clk),
        .srst(srst),
        .load(enter_acq),
        .cycles(acq_len),
        .done(acq_done)
    );

    always_comb begin
        state_d = state_q;
        dma_run_d = dma_run_q;
        case (state_q)
            adc_ctrl_pkg::ST_IDLE: begin
                if (start_req) begin
                    // the bit picks capture at start; capture then runs until a stop entry
                    if (ctrl_q[adc_ctrl_pkg::DMA_POS]) begin
                        state_d = adc_ctrl_pkg::ST_FETCH;
                        dma_run_d = 1'b1;
                    end else begin
                        state_d = adc_ctrl_pkg::ST_ACQ;
                    end
                end
            end
            adc_ctrl_pkg::ST_FETCH: begin
                if (dma_entry_valid) begin
                    if (sel_stop) begin
                        state_d = adc_ctrl_pkg::ST_IDLE;
                        dma_run_d = 1'b0;
                    end else begin
                        state_d = adc_ctrl_pkg::ST_ACQ;
                    end
                end
            end
            adc_ctrl_pkg::ST_ACQ: begin
                if (acq_done) begin
                    state_d = adc_ctrl_pkg::ST_CONV;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (conv_done) begin
                    if (dma_run_q) begin
                        state_d = adc_ctrl_pkg::ST_FETCH;
                    end else if (ctrl_q[adc_ctrl_pkg::CONTINUOUS_CONVERSION_BIT_POS]) begin
                        state_d = adc_ctrl_pkg::ST_ACQ;
                    end else begin
                        state_d = adc_ctrl_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = adc_ctrl_pkg::ST_IDLE;
                dma_run_d = 1'b0;
            end
        endcase
    end

    // hardware set wins over both clears so no completion is lost
    always_comb begin
        ctrl_d = ctrl_q;
        for (int i = 0; i < 8; i++) begin
            if (touch[i]) begin
                ctrl_d[i] = sw_val[i];
            end
        end
        // single bit drops at its end
        if (single_end && !touch[adc_ctrl_pkg::SINGLE_CONVERSION_BIT_POS]) begin
            ctrl_d[adc_ctrl_pkg::SINGLE_CONVERSION_BIT_POS] = 1'b0;
        end
        // dma bit drops at block end
        if (dma_end && !touch[adc_ctrl_pkg::DMA_POS]) begin
            ctrl_d[adc_ctrl_pkg::DMA_POS] = 1'b0;
        end
        if (vector_ack) begin
            ctrl_d[adc_ctrl_pkg::FLAG_POS] = 1'b0;
        end
        if (flag_set) begin
            ctrl_d[adc_ctrl_pkg::FLAG_POS] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= adc_ctrl_pkg::CTRL_RESET;
            state_q <= adc_ctrl_pkg::ST_IDLE;
            dma_run_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            dma_run_q <= dma_run_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chan_q <= 4'h0;
        end else if (enter_acq) begin
            chan_q <= sel_chan;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
            start_q <= 1'b0;
            fetch_q <= 1'b0;
            ale_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            rdata_q <= (sfr_rd && sfr_addr == adc_ctrl_pkg::CTRL_ADDR) ? ctrl_q : 8'h00;
            start_q <= (state_q == adc_ctrl_pkg::ST_ACQ) && acq_done;
            fetch_q <= (state_d == adc_ctrl_pkg::ST_FETCH)
                && (state_q != adc_ctrl_pkg::ST_FETCH);
            // strobe off while armed but not yet running
            ale_q <= !(ctrl_d[adc_ctrl_pkg::DMA_POS] && !dma_run_d);
            busy_q <= state_d != adc_ctrl_pkg::ST_IDLE;
        end
    end

    assign sfr_rdata = rdata_q;
    assign conv_start = start_q;
    assign conv_channel = chan_q;
    assign dma_fetch = fetch_q;
    assign ale_enable = ale_q;
    assign conv_irq = ctrl_q[adc_ctrl_pkg::FLAG_POS];
    assign busy = busy_q;

    sequence seq_single_done;
        in_conv_done && !dma_run_q;
    endsequence

    sequence seq_stop_entry;
        stop_seen;
    endsequence

    a_flag_on_single: assert property (@(posedge sys_clk) disable iff (srst)
        seq_single_done |=> conv_irq)
        else $error("flag not set after single conversion");

    a_flag_vector_clr: assert property (@(posedge sys_clk) disable iff (srst)
        vector_ack && !flag_set |=> !conv_irq)
        else $error("flag not cleared on vector");

    a_single_conversion_bit_self_clr: assert property (@(posedge sys_clk) disable iff (srst)
        seq_single_done ##0 !touch[adc_ctrl_pkg::SINGLE_CONVERSION_BIT_POS]
        |=> !ctrl_q[adc_ctrl_pkg::SINGLE_CONVERSION_BIT_POS])
        else $error("single bit not cleared");

    a_dma_stop_end: assert property (@(posedge sys_clk) disable iff (srst)
        seq_stop_entry ##0 !touch[adc_ctrl_pkg::DMA_POS]
        |=> !ctrl_q[adc_ctrl_pkg::DMA_POS] && conv_irq && !dma_run_q && !busy)
        else $error("stop marker did not end dma");

    a_ale_gated: assert property (@(posedge sys_clk) disable iff (srst)
        ctrl_q[adc_ctrl_pkg::DMA_POS] && !dma_run_q && !$past(srst) |-> !ale_enable)
        else $error("strobe running while dma armed");

    a_cont_restart: assert property (@(posedge sys_clk) disable iff (srst)
        seq_single_done ##0 ctrl_q[adc_ctrl_pkg::CONTINUOUS_CONVERSION_BIT_POS]
        |=> state_q == adc_ctrl_pkg::ST_ACQ)
        else $error("continuous mode did not restart");

    a_field_chan: assert property (@(posedge sys_clk) disable iff (srst)
        enter_acq && !dma_run_q |=> conv_channel == $past(ctrl_q[adc_ctrl_pkg::CHAN_MSB:0]))
        else $error("wrong channel latched");

    a_mem_chan: assert property (@(posedge sys_clk) disable iff (srst)
        enter_acq && dma_run_q |=> conv_channel == $past(dma_entry_chan))
        else $error("dma channel not taken from memory");

    a_temp_wait: assert property (@(posedge sys_clk) disable iff (srst)
        enter_acq && sel_long |=> !conv_start [*8])
        else $error("temperature acquisition too short");

    a_reset_zero: assert property (@(posedge sys_clk)
        srst |=> ctrl_q == 8'h00)
        else $error("register not zero after reset");

    a_single_once: assert property (@(posedge sys_clk) disable iff (srst)
        seq_single_done ##0 !ctrl_q[adc_ctrl_pkg::CONTINUOUS_CONVERSION_BIT_POS] |=> !busy && !conv_start)
        else $error("single request ran more than once");

    a_cont_next_start: assert property (@(posedge sys_clk) disable iff (srst)
        seq_single_done ##0 ctrl_q[adc_ctrl_pkg::CONTINUOUS_CONVERSION_BIT_POS] ##0 !sel_long |=> ##1 conv_start)
        else $error("continuous mode did not start next conversion");

    a_dma_fetch_start: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == adc_ctrl_pkg::ST_IDLE && start_req && ctrl_q[adc_ctrl_pkg::DMA_POS]
        |=> dma_fetch && busy)
        else $error("dma capture did not start");

    a_dma_bit_hold: assert property (@(posedge sys_clk) disable iff (srst)
        dma_run_q && ctrl_q[adc_ctrl_pkg::DMA_POS] && !stop_seen
        && !touch[adc_ctrl_pkg::DMA_POS] |=> ctrl_q[adc_ctrl_pkg::DMA_POS])
        else $error("dma bit dropped during capture");
endmodule
`default_nettype wire

/* logic/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'hd8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int FLAG_POS = 7;
    localparam int DMA_POS = 6;
    localparam int CONTINUOUS_CONVERSION_BIT_POS = 5;
    localparam int SINGLE_CONVERSION_BIT_POS = 4;
    localparam int CHAN_MSB = 3;
    localparam logic [3:0] CH_LAST_EXT = 4'h7;
    localparam logic [3:0] CH_TEMP = 4'h8;
    localparam logic [3:0] CH_STOP = 4'hf;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TEMP_ACQ_NS = 1000;
    // least time, so rounded up
    localparam int TEMP_ACQ_CYC = (TEMP_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BASE_ACQ_CYC = 1;
    localparam int ACQ_CNT_W = 8;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ACQ,
        ST_CONV
    } seq_state_type;
endpackage

/* logic/acq_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module acq_timer #(
    parameter int CNT_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [CNT_W-1:0] cycles,
    output logic done
);
    logic [CNT_W-1:0] cnt_q;
    logic run_q;
    logic last;

    assign last = run_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
    assign done = last;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= cycles;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            run_q <= !last;
        end
    end
endmodule
`default_nettype wire

/* logic/channel_select.sv */
`timescale 1ns/100ps
`default_nettype none
module channel_select (
    input wire logic dma_mode,
    input wire logic [3:0] field_chan,
    input wire logic [3:0] mem_chan,
    output logic [3:0] chan,
    output logic is_stop,
    output logic long_acq
);
    // in dma mode the register field is ignored
    assign chan = dma_mode ? mem_chan : field_chan;
    assign is_stop = dma_mode && (mem_chan == adc_ctrl_pkg::CH_STOP);
    assign long_acq = (chan == adc_ctrl_pkg::CH_TEMP);
endmodule
`default_nettype wire

/* testbench/adc_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_far_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic conv_start,
    input wire logic dma_fetch,
    output logic conv_done,
    output logic dma_entry_valid,
    output logic [3:0] dma_entry_chan
);
    logic [3:0] mem [3] = '{4'h2, 4'h6, 4'hf};
    int conv_cnt = -1;
    int fetch_cnt = -1;
    int idx = 0;
    // driven off the sampling edge, like the bench
    always @(negedge sys_clk) begin
        conv_done = (conv_cnt == 0);
        dma_entry_valid = (fetch_cnt == 0);
        // idle data toggles so a stale entry is never taken as real
        dma_entry_chan = dma_entry_valid ? mem[idx] : ~dma_entry_chan;
        if (dma_entry_valid) begin
            idx = (idx + 1) % 3;
        end
        conv_cnt = conv_start ? (slow ? 6 : 1) : (conv_cnt >= 0 ? conv_cnt - 1 : -1);
        fetch_cnt = dma_fetch ? (slow ? 4 : 0) : (fetch_cnt >= 0 ? fetch_cnt - 1 : -1);
        if (srst) begin
            conv_cnt = -1;
            fetch_cnt = -1;
            idx = 0;
        end
    end
endmodule
`default_nettype wire

/* testbench/adc_conversion_mode_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) bad(8'(g), 8'(e)); end
module adc_conversion_mode_control_tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] bit_addr = 8'h00;
    logic bit_wr = 1'b0;
    logic bit_val = 1'b0;
    logic vector_ack = 1'b0;
    logic trigger_in = 1'b0;
    logic slow = 1'b0;
    logic conv_done, dma_entry_valid, conv_start, dma_fetch, ale_enable, conv_irq, busy;
    logic [3:0] dma_entry_chan, conv_channel;
    logic [7:0] sfr_rdata, q;
    int err_total = 0;
    int tests_run = 0;
    int starts = 0;
    int fetches = 0;
    int done_t = 0;
    int gap = 0;
    int n;
    // addr, write data, expected register value
    logic [23:0] rows [5] = '{24'hd8_05_05, 24'hd8_0c_0c, 24'hd9_0b_0c, 24'h00_ff_0c,
        24'hd8_00_00};
    always #12.5 sys_clk = ~sys_clk;
    adc_conversion_mode_control adc_conversion_mode_control_i (.sys_clk(sys_clk), .srst(srst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_val(bit_val), .vector_ack(vector_ack),
        .trigger_in(trigger_in), .conv_done(conv_done), .dma_entry_valid(dma_entry_valid),
        .dma_entry_chan(dma_entry_chan), .sfr_rdata(sfr_rdata), .conv_start(conv_start),
        .conv_channel(conv_channel), .dma_fetch(dma_fetch), .ale_enable(ale_enable),
        .conv_irq(conv_irq), .busy(busy));
    adc_far_model adc_far_model_i (.sys_clk(sys_clk), .srst(srst), .slow(slow),
        .conv_start(conv_start), .dma_fetch(dma_fetch), .conv_done(conv_done),
        .dma_entry_valid(dma_entry_valid), .dma_entry_chan(dma_entry_chan));
    always @(posedge sys_clk) begin
        if (conv_done) begin
            done_t = int'($time);
        end
        if (dma_fetch) begin
            fetches++;
        end
        if (conv_start) begin
            starts++;
            gap = int'($time) - done_t;
        end
    end
    task automatic bad(input logic [7:0] g, input logic [7:0] e);
        err_total++;
        $display("BAD %0t got %h expected %h", $time, g, e);
    endtask
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        r = sfr_rdata;
        // strobe low for a full cycle before the next read
        @(negedge sys_clk);
    endtask
    task automatic bw(input logic [2:0] b, input logic v);
        bit_addr = {5'h1b, b};
        bit_val = v;
        bit_wr = 1'b1;
        @(negedge sys_clk);
        bit_wr = 1'b0;
    endtask
    task automatic wait_start(output int c);
        c = 0;
        while (conv_start !== 1'b1 && c < 100) begin
            @(negedge sys_clk);
            c++;
        end
        `CHK(c < 100, 1'b1)
    endtask
    task automatic wait_idle();
        int c = 0;
        while (busy !== 1'b0 && c < 200) begin
            @(negedge sys_clk);
            c++;
        end
        `CHK(busy, 1'b0)
    endtask
    initial begin
        #(25 * 5000);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rd(8'hd8, q);
        `CHK(q, 8'h00)
        `CHK({ale_enable, busy, conv_irq}, 3'b100)
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(8'hd8, q);
            `CHK(q, rows[i][7:0])
            rd(rows[i][23:16], q);
            `CHK(q, rows[i][23:16] == 8'hd8 ? rows[i][7:0] : 8'h00)
        end
        wr(8'hd8, 8'h13);
        wait_start(n);
        `CHK(conv_channel, 4'h3)
        wait_idle();
        repeat (10) @(negedge sys_clk);
        `CHK(starts, 1)
        rd(8'hd8, q);
        `CHK(q, 8'h83)
        `CHK(conv_irq, 1'b1)
        vector_ack = 1'b1;
        @(negedge sys_clk);
        vector_ack = 1'b0;
        rd(8'hd8, q);
        `CHK(q, 8'h03)
        wr(8'hd8, 8'h08);
        bw(3'h4, 1'b1);
        wait_start(n);
        `CHK(n >= 40, 1'b1)
        `CHK(conv_channel, 4'h8)
        wait_idle();
        bw(3'h7, 1'b0);
        rd(8'hd8, q);
        `CHK(q, 8'h08)
        slow = 1'b1;
        starts = 0;
        wr(8'hd8, 8'h25);
        repeat (3) begin
            wait_start(n);
            @(negedge sys_clk);
        end
        `CHK(gap, 50)
        `CHK(conv_channel, 4'h5)
        wr(8'hd8, 8'h05);
        wait_idle();
        slow = 1'b0;
        wr(8'hd8, 8'h43);
        @(negedge sys_clk);
        `CHK(ale_enable, 1'b0)
        `CHK(busy, 1'b0)
        starts = 0;
        trigger_in = 1'b1;
        @(negedge sys_clk);
        trigger_in = 1'b0;
        wait_start(n);
        `CHK(ale_enable, 1'b1)
        `CHK(conv_channel, 4'h2)
        @(negedge sys_clk);
        wait_start(n);
        `CHK(conv_channel, 4'h6)
        wait_idle();
        rd(8'hd8, q);
        `CHK(q, 8'h83)
        `CHK(starts, 2)
        `CHK(fetches, 3)
        `CHK(ale_enable, 1'b1)
        wr(8'hd8, 8'h25);
        repeat (3) @(negedge sys_clk);
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rd(8'hd8, q);
        `CHK(q, 8'h00)
        `CHK({ale_enable, busy}, 2'b10)
        finish_test();
    end
endmodule
`default_nettype wire
